// >>> src/dsos_pkg.sv
// Package with codes, offsets and reset values of the drive shutoff and output selector.
package dsos_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_STATUS     = 8'h04;
  localparam logic [7:0] OFS_OUT_SEL0   = 8'h10;
  localparam logic [7:0] OFS_TERM_STATE = 8'h28;
  localparam logic [7:0] OFS_COND       = 8'h2c;
  // ----------------------------------------
  // Control field positions and reset values
  // ----------------------------------------
  localparam int          CTRL_POL_LSB   = 0;
  localparam int          CTRL_STOP_LSB  = 8;
  localparam int          CTRL_INFN_LSB  = 24;
  localparam logic [2:0]  POL_RST        = 3'h0;
  localparam logic [2:0]  POL_NC         = 3'h2;
  localparam logic [15:0] STOP_RST       = 16'h270f;
  localparam logic [15:0] STOP_COAST_MAX = 16'h0064;
  localparam logic [7:0]  INFN_SHUTOFF   = 8'h18;
  localparam logic [7:0]  INFN_RST       = 8'h18;
  // ----------------------------------------
  // Output selector codes
  // ----------------------------------------
  localparam int          NUM_OUT        = 6;
  localparam logic [15:0] SEL_NEG_BASE   = 16'h0064;
  localparam logic [15:0] SEL_NEG_MAX    = 16'h00c7;
  localparam logic [15:0] SEL_NONE       = 16'h270f;
  localparam logic [15:0] SEL_RST0       = 16'h0000;
  localparam logic [15:0] SEL_RST1       = 16'h0004;
  localparam logic [15:0] SEL_RST2       = 16'h0063;
  localparam logic [6:0]  C_RUN          = 7'h00;
  localparam logic [6:0]  C_SU           = 7'h01;
  localparam logic [6:0]  C_OL           = 7'h03;
  localparam logic [6:0]  C_FU           = 7'h04;
  localparam logic [6:0]  C_RBP          = 7'h07;
  localparam logic [6:0]  C_THP          = 7'h08;
  localparam logic [6:0]  C_RDY          = 7'h0b;
  localparam logic [6:0]  C_IDET         = 7'h0c;
  localparam logic [6:0]  C_ZDET         = 7'h0d;
  localparam logic [6:0]  C_LLOW         = 7'h0e;
  localparam logic [6:0]  C_LHIGH        = 7'h0f;
  localparam logic [6:0]  C_LFWD         = 7'h10;
  localparam logic [6:0]  C_BRK          = 7'h14;
  localparam logic [6:0]  C_FAN          = 7'h19;
  localparam logic [6:0]  C_FIN          = 7'h1a;
  localparam logic [6:0]  C_PFD          = 7'h2e;
  localparam logic [6:0]  C_LOOP         = 7'h2f;
  localparam logic [6:0]  C_AVG          = 7'h5d;
  localparam logic [6:0]  C_REM          = 7'h60;
  localparam logic [6:0]  C_FAULT        = 7'h63;
  // Duty and thermal pre-alarm threshold, percent of the limit.
  localparam logic [7:0]  PREALARM_PCT   = 8'h55;
  localparam logic [7:0]  TRIP_PCT       = 8'h64;
endpackage

// >>> src/dsos_top.sv
// Drive output shutoff and status output selector with an APB register slave.
//
// Function
// - Active shutoff cuts running output at once.
// - Polarity resets 0; 0,4 NO, 2 NC.
// - Active shutoff blocks any start command.
// - Start removal ramps down; shutoff coasts.
// - Stop selection 0 to 100 makes coasting.
// - Input function 24 maps shutoff to terminal.
// - Codes 0-99 positive, 100-199 negative.
// - Selectors reset to 0,4,99,9999,9999,9999.
// - Running when frequency at least starting frequency.
// - Frequency reached flag when set frequency reached.
// - Overload flag while stall prevention active.
// - Detect flag at level, reverse level separate.
// - Brake pre-alarm at 85% duty limit.
// - Thermal pre-alarm 85%, trip at 100%.
// - Ready after reset processing, stays while running.
// - Current detect after above threshold too long.
// - Zero current after below level too long.
// - Loop low, high, forward, active flags.
// - Brake open only with brake sequence selected.
// - Fan fault 25; heatsink pre-alarm 26.
// - Power-fail decel flag latched until release.
// - Third refuses 93/193; 96/196 first only.
`timescale 1ns/1ps
module dsos_top #(
  parameter int TIME_W = 16
) (
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic              output_shutoff_in,
  input  wire logic              shutoff_net_in,
  input  wire logic              start_cmd,
  input  wire logic              reverse_dir,
  input  wire logic [15:0]       out_freq,
  input  wire logic [15:0]       set_freq,
  input  wire logic [15:0]       start_freq,
  input  wire logic [15:0]       detect_freq_fwd,
  input  wire logic [15:0]       detect_freq_rev,
  input  wire logic              stall_active,
  input  wire logic [7:0]        regen_duty_pct,
  input  wire logic [7:0]        thermal_pct,
  input  wire logic              reset_proc_done,
  input  wire logic [15:0]       out_current,
  input  wire logic [15:0]       current_thresh,
  input  wire logic [TIME_W-1:0] current_time,
  input  wire logic [15:0]       zero_level,
  input  wire logic [TIME_W-1:0] zero_time,
  input  wire logic              loop_active,
  input  wire logic              loop_below_low,
  input  wire logic              loop_above_high,
  input  wire logic              loop_forward,
  input  wire logic              brake_seq_sel,
  input  wire logic              brake_release,
  input  wire logic              fan_fault,
  input  wire logic [7:0]        heatsink_pct,
  input  wire logic              powerfail_decel_run,
  input  wire logic              powerfail_release,
  input  wire logic              fault_flag,
  input  wire logic              avg_monitor_pulse,
  input  wire logic              remote_out_bit,
  output logic                   power_enable,
  output logic                   ramp_stop,
  output logic                   coast_stop,
  output logic                   thermal_trip,
  output logic                   open_collector_out,
  output logic                   net_out_term_a,
  output logic                   net_out_term_b,
  output logic                   net_out_term_c,
  output logic                   net_out_term_d,
  output logic                   net_out_term_e,
  output logic                   net_out_term_f
);
  // ----------------------------------------
  // Selector decode
  // ----------------------------------------
  // Returns {valid, negative, condition index} for a selector code.
  function automatic logic [8:0] sel_decode(input logic [15:0] code);
    logic [15:0] base;
    base = (code >= dsos_pkg::SEL_NEG_BASE) ? code - dsos_pkg::SEL_NEG_BASE : code;
    sel_decode = {(code <= dsos_pkg::SEL_NEG_MAX), (code >= dsos_pkg::SEL_NEG_BASE),
                  base[6:0]};
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [2:0]          pol_r;
  logic [15:0]         stop_r;
  logic [7:0]          infn_r;
  logic [15:0]         sel_r [dsos_pkg::NUM_OUT];
  logic [TIME_W-1:0]   icnt_r;
  logic [TIME_W-1:0]   zcnt_r;
  logic                idet_r;
  logic                zdet_r;
  logic                pfd_r;
  logic                running_r;
  logic [dsos_pkg::NUM_OUT-1:0] term_r;

  wire access   = psel & penable;
  wire wr       = access & pwrite;
  wire sel_hit  = (paddr >= dsos_pkg::OFS_OUT_SEL0) && (paddr < dsos_pkg::OFS_TERM_STATE)
                  && (paddr[1:0] == 2'h0);
  wire [2:0] sel_idx = 3'((paddr - dsos_pkg::OFS_OUT_SEL0) >> 2);
  wire known    = sel_hit || paddr == dsos_pkg::OFS_CTRL || paddr == dsos_pkg::OFS_STATUS
                  || paddr == dsos_pkg::OFS_TERM_STATE || paddr == dsos_pkg::OFS_COND;
  wire [15:0] wsel = pwdata[15:0];
  // The third selector has no pulse train output, so those codes are refused there.
  wire sel_refused = (sel_idx == 3'h2) && (wsel == 16'(dsos_pkg::C_AVG)
                     || wsel == 16'(dsos_pkg::C_AVG) + dsos_pkg::SEL_NEG_BASE);

  // ----------------------------------------
  // Shutoff and stop control
  // ----------------------------------------
  wire shutoff_mapped = (infn_r == dsos_pkg::INFN_SHUTOFF);
  wire shutoff_raw    = shutoff_mapped ? shutoff_net_in : 1'b0;
  wire shutoff_pin    = (pol_r == dsos_pkg::POL_NC) ? ~output_shutoff_in
                                                     : output_shutoff_in;
  wire shutoff_act    = shutoff_raw | shutoff_pin;
  wire run_allowed    = start_cmd & ~shutoff_act;
  wire stop_coast_sel = (stop_r <= dsos_pkg::STOP_COAST_MAX);

  // ----------------------------------------
  // Condition vector
  // ----------------------------------------
  wire [15:0] det_lvl = reverse_dir ? detect_freq_rev : detect_freq_fwd;
  logic [127:0] cond;
  always_comb begin
    cond                    = '0;
    cond[dsos_pkg::C_RUN]   = running_r && (out_freq >= start_freq);
    cond[dsos_pkg::C_SU]    = (out_freq == set_freq);
    cond[dsos_pkg::C_OL]    = stall_active;
    cond[dsos_pkg::C_FU]    = (out_freq >= det_lvl);
    cond[dsos_pkg::C_RBP]   = (regen_duty_pct >= dsos_pkg::PREALARM_PCT);
    cond[dsos_pkg::C_THP]   = (thermal_pct >= dsos_pkg::PREALARM_PCT);
    cond[dsos_pkg::C_RDY]   = reset_proc_done | running_r;
    cond[dsos_pkg::C_IDET]  = idet_r;
    cond[dsos_pkg::C_ZDET]  = zdet_r;
    cond[dsos_pkg::C_LLOW]  = loop_active & loop_below_low;
    cond[dsos_pkg::C_LHIGH] = loop_active & loop_above_high;
    cond[dsos_pkg::C_LFWD]  = loop_active & loop_forward;
    cond[dsos_pkg::C_LOOP]  = loop_active;
    cond[dsos_pkg::C_BRK]   = brake_seq_sel & brake_release;
    cond[dsos_pkg::C_FAN]   = fan_fault;
    cond[dsos_pkg::C_FIN]   = (heatsink_pct >= dsos_pkg::PREALARM_PCT);
    cond[dsos_pkg::C_PFD]   = pfd_r;
    cond[dsos_pkg::C_AVG]   = avg_monitor_pulse;
    cond[dsos_pkg::C_FAULT] = fault_flag;
  end

  // ----------------------------------------
  // Terminal drive
  // ----------------------------------------
  logic [dsos_pkg::NUM_OUT-1:0] term_nxt;
  for (genvar g = 0; g < dsos_pkg::NUM_OUT; g++) begin : g_term
    wire [8:0] d      = sel_decode(sel_r[g]);
    // Remote output is a software bit and only the first selector carries it, to the open-collector output and net terminal a.
    wire       remote = (d[6:0] == dsos_pkg::C_REM);
    wire       level  = remote ? ((g == 0) & remote_out_bit) : cond[d[6:0]];
    wire       void_f = remote && g != 0;
    assign term_nxt[g] = d[8] & ~void_f & (level ^ d[7]);
  end

  // ----------------------------------------
  // APB read mux
  // ----------------------------------------
  wire [31:0] ctrl_rd = {infn_r, stop_r, 5'h0, pol_r};
  wire [31:0] stat_rd = {26'h0, pfd_r, thermal_trip, shutoff_act, coast_stop, ramp_stop,
                         power_enable};
  wire [31:0] rd_data =
    sel_hit                          ? {16'h0, sel_r[sel_idx]} :
    paddr == dsos_pkg::OFS_CTRL      ? ctrl_rd :
    paddr == dsos_pkg::OFS_STATUS    ? stat_rd :
    paddr == dsos_pkg::OFS_TERM_STATE ? {26'h0, term_r} :
    paddr == dsos_pkg::OFS_COND      ? cond[31:0] : 32'h0;

  // ----------------------------------------
  // Bus response
  // ----------------------------------------
  // Read data is loaded at the setup edge only, so it stands for the access cycle alone.
  wire setup_ph = psel & ~penable;
  wire wr_take  = wr & pready;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph & ~known;
      prdata  <= (setup_ph & ~pwrite) ? rd_data : 32'h0;
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  // A polarity change takes effect on the next edge, even while running.
  wire ctrl_wr = wr_take && (paddr == dsos_pkg::OFS_CTRL);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pol_r  <= dsos_pkg::POL_RST;
      stop_r <= dsos_pkg::STOP_RST;
      infn_r <= dsos_pkg::INFN_RST;
    end else if (ctrl_wr) begin
      pol_r  <= pwdata[dsos_pkg::CTRL_POL_LSB +: 3];
      stop_r <= pwdata[dsos_pkg::CTRL_STOP_LSB +: 16];
      infn_r <= pwdata[dsos_pkg::CTRL_INFN_LSB +: 8];
    end
  end

  // ----------------------------------------
  // Selector registers
  // ----------------------------------------
  // Out-of-range codes are dropped silently; the bus still completes without an error.
  wire code_ok = (wsel <= dsos_pkg::SEL_NEG_MAX) || (wsel == dsos_pkg::SEL_NONE);
  wire sel_wr  = wr_take && sel_hit && !sel_refused && code_ok;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sel_r[0] <= dsos_pkg::SEL_RST0;
      sel_r[1] <= dsos_pkg::SEL_RST1;
      sel_r[2] <= dsos_pkg::SEL_RST2;
      sel_r[3] <= dsos_pkg::SEL_NONE;
      sel_r[4] <= dsos_pkg::SEL_NONE;
      sel_r[5] <= dsos_pkg::SEL_NONE;
    end else if (sel_wr) begin
      sel_r[sel_idx] <= wsel;
    end
  end

  // ----------------------------------------
  // Drive state
  // ----------------------------------------
  // Shutoff bypasses any ramp: the output drops on the next edge and the motor coasts.
  wire coast_nxt = shutoff_act | (~start_cmd & stop_coast_sel);
  wire ramp_nxt  = ~shutoff_act & ~start_cmd & ~stop_coast_sel;
  wire trip_nxt  = (thermal_pct >= dsos_pkg::TRIP_PCT);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      running_r    <= 1'b0;
      power_enable <= 1'b0;
      ramp_stop    <= 1'b0;
      coast_stop   <= 1'b0;
      thermal_trip <= 1'b0;
    end else begin
      running_r    <= run_allowed;
      power_enable <= run_allowed;
      coast_stop   <= coast_nxt;
      ramp_stop    <= ramp_nxt;
      thermal_trip <= trip_nxt;
    end
  end

  // ----------------------------------------
  // Current detector
  // ----------------------------------------
  // The counter saturates one past the limit, so a long overcurrent never wraps.
  wire i_over = (out_current > current_thresh);
  wire i_full = (icnt_r > current_time);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      icnt_r <= '0;
      idet_r <= 1'b0;
    end else if (!i_over) begin
      icnt_r <= '0;
      idet_r <= 1'b0;
    end else begin
      if (!i_full) begin
        icnt_r <= icnt_r + 1'b1;
      end
      idet_r <= i_full;
    end
  end

  // ----------------------------------------
  // Zero current detector
  // ----------------------------------------
  wire z_under = (out_current < zero_level);
  wire z_full  = (zcnt_r > zero_time);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      zcnt_r <= '0;
      zdet_r <= 1'b0;
    end else if (!z_under) begin
      zcnt_r <= '0;
      zdet_r <= 1'b0;
    end else begin
      if (!z_full) begin
        zcnt_r <= zcnt_r + 1'b1;
      end
      zdet_r <= z_full;
    end
  end

  // ----------------------------------------
  // Power-fail latch
  // ----------------------------------------
  // A new event in the cycle of a release wins, so no event is lost.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pfd_r <= 1'b0;
    end else begin
      pfd_r <= powerfail_decel_run | (pfd_r & ~powerfail_release);
    end
  end

  // ----------------------------------------
  // Terminal register
  // ----------------------------------------
  // Registering the terminals keeps decode glitches off the pins.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      term_r <= '0;
    end else begin
      term_r <= term_nxt;
    end
  end

  assign open_collector_out = term_r[0];
  assign net_out_term_a     = term_r[0];
  assign net_out_term_b     = term_r[1];
  assign net_out_term_c     = term_r[2];
  assign net_out_term_d     = term_r[3];
  assign net_out_term_e     = term_r[4];
  assign net_out_term_f     = term_r[5];
endmodule // dsos_top

// >>> verification/drive_shutoff_and_status_output_select_test.sv
// Self-checking bench for the drive shutoff and status output selector.
`timescale 1ns/1ps
module drive_shutoff_and_status_output_select_test;
  logic        sys_clk, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        output_shutoff_in, shutoff_net_in, start_cmd, reverse_dir, stall_active;
  logic        reset_proc_done, loop_active, loop_below_low, loop_above_high, loop_forward;
  logic        brake_seq_sel, brake_release, fan_fault, powerfail_decel_run;
  logic        powerfail_release, fault_flag, avg_monitor_pulse, remote_out_bit;
  logic [15:0] out_freq, set_freq, start_freq, detect_freq_fwd, detect_freq_rev;
  logic [15:0] out_current, current_thresh, zero_level, current_time, zero_time;
  logic [7:0]  regen_duty_pct, thermal_pct, heatsink_pct;
  logic        power_enable, ramp_stop, coast_stop, thermal_trip, open_collector_out;
  logic        net_out_term_a, net_out_term_b, net_out_term_c, net_out_term_d;
  logic        net_out_term_e, net_out_term_f;
  logic [5:0]  term_snap;
  logic [31:0] rst_sel [6] = '{32'h0, 32'h4, 32'h63, 32'h270f, 32'h270f, 32'h270f};
  int          bad_count, check_count;

  dsos_top #(.TIME_W(16)) dsos_top_i (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .output_shutoff_in, .shutoff_net_in, .start_cmd,
    .reverse_dir, .out_freq, .set_freq, .start_freq, .detect_freq_fwd, .detect_freq_rev,
    .stall_active, .regen_duty_pct, .thermal_pct, .reset_proc_done, .out_current,
    .current_thresh, .current_time, .zero_level, .zero_time, .loop_active, .loop_below_low,
    .loop_above_high, .loop_forward, .brake_seq_sel, .brake_release, .fan_fault,
    .heatsink_pct, .powerfail_decel_run, .powerfail_release, .fault_flag, .avg_monitor_pulse,
    .remote_out_bit, .power_enable, .ramp_stop, .coast_stop, .thermal_trip,
    .open_collector_out, .net_out_term_a, .net_out_term_b, .net_out_term_c, .net_out_term_d,
    .net_out_term_e, .net_out_term_f);
  dsos_net_master dsos_net_master_i (.sys_clk, .rstn, .net_out_term_a, .net_out_term_b,
    .net_out_term_c, .net_out_term_d, .net_out_term_e, .net_out_term_f, .term_snap);

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // The request is held until pready is seen; one idle edge follows every transfer.
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      bad_count++;
      report_and_stop();
    end
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, e);
    xfer(a, 1'b0, 32'h0);
    chk(nm, rd & m, e);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, output_shutoff_in, shutoff_net_in} = '0;
    {start_cmd, reverse_dir, stall_active, reset_proc_done, loop_active} = '0;
    {loop_below_low, loop_above_high, loop_forward, brake_seq_sel, brake_release} = '0;
    {fan_fault, powerfail_decel_run, powerfail_release, fault_flag} = '0;
    {avg_monitor_pulse, remote_out_bit, out_freq, set_freq, start_freq} = '0;
    {detect_freq_fwd, detect_freq_rev, out_current, current_thresh, zero_level} = '0;
    {current_time, zero_time, regen_duty_pct, thermal_pct, heatsink_pct} = '0;
    bad_count = 0;
    check_count = 0;
    rstn = 1'b0;
    tick(12);
    rstn <= 1'b1;
    tick(2);
    rdc("ctrl", dsos_pkg::OFS_CTRL, '1, 32'h18270f00);
    foreach (rst_sel[i]) rdc("sel", dsos_pkg::OFS_OUT_SEL0 + 8'(4 * i), '1, rst_sel[i]);
    $display("reset values done");
    start_cmd <= 1'b1;
    tick(3);
    chk("run", power_enable, 1'b1);
    output_shutoff_in <= 1'b1;
    tick(2);
    chk("cut", power_enable, 1'b0);
    chk("coast", coast_stop, 1'b1);
    tick(3);
    chk("blocked", power_enable, 1'b0);
    output_shutoff_in <= 1'b0;
    wr(dsos_pkg::OFS_CTRL, 32'h18270f02);
    tick(2);
    chk("nc open", power_enable, 1'b0);
    output_shutoff_in <= 1'b1;
    tick(3);
    chk("nc closed", power_enable, 1'b1);
    wr(dsos_pkg::OFS_CTRL, 32'h18270f04);
    tick(2);
    chk("no active", power_enable, 1'b0);
    output_shutoff_in <= 1'b0;
    start_cmd <= 1'b0;
    tick(3);
    chk("ramp", ramp_stop, 1'b1);
    wr(dsos_pkg::OFS_CTRL, 32'h18006400);
    start_cmd <= 1'b1;
    tick(3);
    start_cmd <= 1'b0;
    tick(3);
    chk("stop coast", coast_stop, 1'b1);
    $display("shutoff tests done");
    stall_active <= 1'b1;
    wr(8'h1c, 32'h3);
    tick(2);
    chk("pos", net_out_term_d, 1'b1);
    wr(8'h1c, 32'h67);
    tick(2);
    chk("neg", net_out_term_d, 1'b0);
    chk("none", net_out_term_e, 1'b0);
    chk("none f", net_out_term_f, 1'b0);
    chk("fault off", net_out_term_c, 1'b0);
    chk("none net", term_snap[4], 1'b0);
    wr(8'h18, 32'h5d);
    rdc("sel2 refuse", 8'h18, '1, 32'h63);
    wr(8'h1c, 32'hc8);
    rdc("sel3 range", 8'h1c, '1, 32'h67);
    remote_out_bit <= 1'b1;
    wr(8'h1c, 32'h60);
    tick(2);
    chk("remote off", net_out_term_d, 1'b0);
    wr(8'h10, 32'h60);
    tick(2);
    chk("remote on", open_collector_out, 1'b1);
    chk("remote net", term_snap[0], 1'b1);
    {loop_active, loop_below_low, loop_above_high, loop_forward} <= 4'hf;
    {fan_fault, brake_seq_sel, brake_release, reset_proc_done} <= 4'hf;
    {regen_duty_pct, thermal_pct, heatsink_pct} <= {8'h55, 8'h64, 8'h55};
    tick(3);
    rdc("cond", dsos_pkg::OFS_COND, 32'h0611f988, 32'h0611c988);
    chk("trip", thermal_trip, 1'b1);
    brake_seq_sel <= 1'b0;
    tick(2);
    rdc("brake", dsos_pkg::OFS_COND, 32'h00100000, 32'h0);
    {out_current, current_thresh, current_time} <= {16'h10, 16'h5, 16'h3};
    rdc("idet early", dsos_pkg::OFS_COND, 32'h1000, 32'h0);
    tick(8);
    rdc("idet late", dsos_pkg::OFS_COND, 32'h1000, 32'h1000);
    powerfail_decel_run <= 1'b1;
    tick(1);
    powerfail_decel_run <= 1'b0;
    tick(3);
    rdc("pf held", dsos_pkg::OFS_STATUS, 32'h20, 32'h20);
    powerfail_release <= 1'b1;
    tick(2);
    powerfail_release <= 1'b0;
    tick(2);
    rdc("pf freed", dsos_pkg::OFS_STATUS, 32'h20, 32'h0);
    {start_freq, set_freq, out_freq} <= {16'h10, 16'h20, 16'h20};
    {detect_freq_fwd, detect_freq_rev} <= {16'h18, 16'h40};
    start_cmd <= 1'b1;
    reverse_dir <= 1'b1;
    tick(3);
    rdc("run su", dsos_pkg::OFS_COND, 32'h13, 32'h3);
    chk("fu rev", net_out_term_b, 1'b0);
    reverse_dir <= 1'b0;
    tick(2);
    chk("fu fwd", net_out_term_b, 1'b1);
    shutoff_net_in <= 1'b1;
    tick(2);
    chk("net shutoff", power_enable, 1'b0);
    xfer(8'h30, 1'b0, 32'h0);
    chk("unmapped err", err, 1'b1);
    chk("unmapped rd", rd, 32'h0);
    $display("selector tests done");
    report_and_stop();
  end
endmodule // drive_shutoff_and_status_output_select_test

bind dsos_top dsos_sva dsos_sva_i (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .prdata, .pslverr, .output_shutoff_in, .start_cmd, .thermal_pct, .power_enable,
  .thermal_trip);

// >>> verification/dsos_net_master.sv
// Model of the fieldbus master that polls the six network output terminals.
`timescale 1ns/1ps
module dsos_net_master (
  input wire logic  sys_clk,
  input wire logic  rstn,
  input wire logic  net_out_term_a,
  input wire logic  net_out_term_b,
  input wire logic  net_out_term_c,
  input wire logic  net_out_term_d,
  input wire logic  net_out_term_e,
  input wire logic  net_out_term_f,
  output logic [5:0] term_snap
);
  // The master only samples; it never drives the terminals back.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      term_snap <= 6'h00;
    end else begin
      term_snap <= {net_out_term_f, net_out_term_e, net_out_term_d,
                    net_out_term_c, net_out_term_b, net_out_term_a};
    end
  end
endmodule // dsos_net_master

// >>> verification/dsos_sva.sv
// Checker of the bus handshake and shutoff behaviour at the selector ports.
`timescale 1ns/1ps
module dsos_sva (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        output_shutoff_in,
  input wire logic        start_cmd,
  input wire logic [7:0]  thermal_pct,
  input wire logic        power_enable,
  input wire logic        thermal_trip
);
  logic [2:0] pol_r;
  logic       shut_act;

  // Polarity is mirrored from bus writes because the checker cannot see the register.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pol_r <= 3'h0;
    end else if (psel && penable && pready && pwrite && paddr == 8'h00) begin
      pol_r <= pwdata[2:0];
    end
  end
  assign shut_act = (pol_r == 3'h2) ? !output_shutoff_in : output_shutoff_in;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_done; psel && penable && pready; endsequence

  a_ready_setup: assert property (s_setup |=> pready) else $error("no answer after setup");
  a_ready_once: assert property (s_done |=> !pready) else $error("pready held too long");
  a_ready_idle: assert property (!psel |-> !pready) else $error("pready without select");
  a_err_unmapped: assert property (s_done ##0 (paddr > 8'h2c) |-> pslverr)
    else $error("unmapped access not flagged");
  a_err_ready: assert property (pslverr |-> pready) else $error("error outside access");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("stray read data");
  a_shutoff_cut: assert property (shut_act |=> !power_enable)
    else $error("output on while shutoff active");
  a_stop_removed: assert property (!start_cmd |=> !power_enable)
    else $error("output on without start");
  a_trip_full: assert property (thermal_pct >= 8'h64 |=> thermal_trip)
    else $error("no thermal trip at full level");
endmodule // dsos_sva
